// ==== design/dlgcs_pkg.sv ====
// Constants shared by the link guard, calibration and slew logic.
// Assumes a 125 MHz reference clock and a separate serial link clock.
// Notes on behaviour
// - Keep-alive watchdog runs only when enabled
// - Period select picks 10, 51, 102, 204 ms
// - Missed keep-alive: alarm low, keep-alive fault set
// - Keep-alive fault cleared by reset, disable; soft reset, power-down only after a kick
// - Frame check only when enabled; 32-bit frames then
// - Check polynomial is x^8 + x^2 + x + 1
// - Readback with check sends 32 bits with CRC
// - Non-zero remainder: alarm low, check fault set
// - Check fault cleared by reset, disable, soft reset, power-down
// - Frame failing check writes nothing
// - Output equals code times gain, plus zero trim
// - Gain trim resets to zero, half gain
// - Corrected code saturates to valid range
// - Control bit 4 enables slew; fields 7:5, 11:8
// - Step codes give 1 to 128 LSB
// - Rate codes give 258,065 Hz to 3,300 Hz
// - Data readback returns present intermediate value
// - Clear slews to clear value when slewing
// - Status bit 1 shows slew in progress
// - Plain frame: 8-bit address, 16-bit data, MSB first
package dlgcs_pkg;

  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int KA_PERIOD_MS [4] = '{10, 51, 102, 204};
  localparam int SLEW_FREQ_HZ [16] = '{258065, 200000, 153845, 131145, 115940, 69565,
    37560, 25805, 20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300};

  localparam int KA_CNT_W = 25;
  localparam int SLEW_CNT_W = 16;

  localparam logic [7:0] KEEPALIVE_ADDR = 8'h95;
  localparam logic [7:0] DATA_ADDR = 8'h01;
  localparam logic [7:0] READBACK_ADDR = 8'h02;

  localparam logic [7:0] CRC_POLY_LOW = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam int PLAIN_FRAME_BITS = 24;
  localparam int CHECKED_FRAME_BITS = 32;

  localparam logic [16:0] GAIN_OFFSET = 17'h08000;
  localparam logic [15:0] GAIN_TRIM_RESET = 16'h0000;
  localparam logic [15:0] CODE_MAX = 16'hffff;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CLEAR_CODE = 16'h0000;

  localparam int SLEW_EN_BIT = 4;
  localparam int SLEW_STEP_LSB = 5;
  localparam int SLEW_RATE_LSB = 8;

  localparam int STAT_SLEW_BIT = 1;
  localparam int STAT_CHECK_FAULT_BIT = 3;
  localparam int STAT_KEEPALIVE_FAULT_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage

// ==== design/dlgcs_top.sv ====
// Link guard, frame check, gain and zero trim, and digital slew stepper.
// Assumes SCLK stops outside frames and LATCH rises only after the last SCLK edge.
`timescale 1ns/10ps
module dlgcs_top
  import dlgcs_pkg::*;
#(
  parameter int KA_TIME_DIV = 1,
  parameter int SLEW_TIME_DIV = 1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_SCLK,
  input wire logic I_SDI,
  input wire logic I_LATCH,
  input wire logic I_CLEAR_INPUT,
  input wire logic I_KEEPALIVE_ENABLE,
  input wire logic [1:0] I_KEEPALIVE_PERIOD_SELECT,
  input wire logic I_FRAME_CHECK_ENABLE,
  input wire logic I_SOFT_RESET,
  input wire logic I_POWER_DOWN,
  input wire logic [15:0] I_GAIN_TRIM,
  input wire logic [15:0] I_ZERO_TRIM,
  input wire logic [15:0] I_SLEW_CONTROL,
  output logic O_SDO,
  output logic O_ALARM_O,
  output logic O_ALARM_OE,
  output logic [7:0] O_STATUS,
  output logic [15:0] O_OUTPUT_CODE,
  output logic O_WRITE_STROBE,
  output logic [7:0] O_WRITE_ADDR,
  output logic [15:0] O_WRITE_DATA
);

  function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      if (i < n) begin
        fb = c[7] ^ d[i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 8'h00);
      end
    end
    return c;
  endfunction

  function automatic logic [KA_CNT_W-1:0] ka_limit(input logic [1:0] sel);
    int n;
    n = (KA_PERIOD_MS[sel] * CLK_PER_MS) / KA_TIME_DIV;
    if (n < 1) begin
      n = 1;
    end
    return KA_CNT_W'(n);
  endfunction

  function automatic logic [SLEW_CNT_W-1:0] slew_limit(input logic [3:0] sel);
    int n;
    n = (CLK_HZ / SLEW_FREQ_HZ[sel]) / SLEW_TIME_DIV;
    if (n < 1) begin
      n = 1;
    end
    return SLEW_CNT_W'(n);
  endfunction

  // Link clock domain: receive shift register, MSB first
  logic [31:0] rx_shift_reg;

  always_ff @(posedge I_SCLK) begin
    rx_shift_reg <= {rx_shift_reg[30:0], I_SDI};
  end

  // Pin synchronisers: bit 0 latch, bit 1 serial clock, bit 2 clear
  logic [2:0] pin_in;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_lvl_reg;
  logic [2:0] pin_lvl_next;

  assign pin_in = {I_CLEAR_INPUT, I_SCLK, I_LATCH};

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      pin_s3_reg <= 3'h0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Level changes only where second and third stages agree
  assign pin_lvl_next = (pin_s2_reg & pin_s3_reg) | (pin_lvl_reg & (pin_s2_reg | pin_s3_reg));

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pin_lvl_reg <= 3'h0;
    end else begin
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  logic latch_rise;
  logic sclk_fall;
  logic clear_lvl;

  assign latch_rise = pin_lvl_next[0] & ~pin_lvl_reg[0];
  assign sclk_fall = ~pin_lvl_next[1] & pin_lvl_reg[1];
  assign clear_lvl = pin_lvl_reg[2];

  // Frame decode at latch; link clock is idle so the shift register is stable
  logic [23:0] rx_content;
  logic crc_bad;
  logic frame_ok;
  logic [7:0] rx_addr;
  logic [15:0] rx_data;

  always_comb begin
    if (I_FRAME_CHECK_ENABLE) begin
      rx_content = rx_shift_reg[31:8];
    end else begin
      rx_content = rx_shift_reg[23:0];
    end
  end

  assign rx_addr = rx_content[23:16];
  assign rx_data = rx_content[15:0];
  assign crc_bad = I_FRAME_CHECK_ENABLE && (crc8(rx_shift_reg, CHECKED_FRAME_BITS) != 8'h00);
  assign frame_ok = latch_rise && !crc_bad;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_WRITE_STROBE <= 1'b0;
      O_WRITE_ADDR <= 8'h00;
      O_WRITE_DATA <= 16'h0000;
    end else begin
      O_WRITE_STROBE <= frame_ok;
      if (frame_ok) begin
        O_WRITE_ADDR <= rx_addr;
        O_WRITE_DATA <= rx_data;
      end
    end
  end

  // Keep-alive watchdog
  logic ka_en_prev_reg;
  logic [KA_CNT_W-1:0] ka_count_reg;
  logic ka_fault_reg;
  logic ka_kick;
  logic ka_expired;

  assign ka_kick = frame_ok && (rx_addr == KEEPALIVE_ADDR);
  assign ka_expired = I_KEEPALIVE_ENABLE && (ka_count_reg == ka_limit(I_KEEPALIVE_PERIOD_SELECT));

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ka_en_prev_reg <= 1'b0;
    end else begin
      ka_en_prev_reg <= I_KEEPALIVE_ENABLE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || !I_KEEPALIVE_ENABLE) begin
      ka_count_reg <= '0;
    end else if (ka_kick || !ka_en_prev_reg) begin
      ka_count_reg <= '0;
    end else if (!ka_expired) begin
      ka_count_reg <= ka_count_reg + 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ka_fault_reg <= 1'b0;
    end else if (ka_expired) begin
      ka_fault_reg <= 1'b1;
    end else if (I_SOFT_RESET || I_POWER_DOWN || !I_KEEPALIVE_ENABLE) begin
      ka_fault_reg <= 1'b0;
    end
  end

  // Frame check fault
  logic crc_fault_reg;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      crc_fault_reg <= 1'b0;
    end else if (latch_rise && crc_bad) begin
      crc_fault_reg <= 1'b1;
    end else if (I_SOFT_RESET || I_POWER_DOWN || !I_FRAME_CHECK_ENABLE) begin
      crc_fault_reg <= 1'b0;
    end
  end

  // Open-drain alarm: drive low while any fault stands
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_ALARM_O <= 1'b0;
      O_ALARM_OE <= 1'b0;
    end else begin
      O_ALARM_O <= 1'b0;
      O_ALARM_OE <= ka_fault_reg | crc_fault_reg;
    end
  end

  // Data code and clear hold
  logic [15:0] data_code_reg;
  logic clear_hold_reg;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      data_code_reg <= CODE_RESET;
    end else if (frame_ok && !clear_lvl && (rx_addr == DATA_ADDR)) begin
      data_code_reg <= rx_data;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      clear_hold_reg <= 1'b0;
    end else if (clear_lvl) begin
      clear_hold_reg <= 1'b1;
    end else if (latch_rise) begin
      clear_hold_reg <= 1'b0;
    end
  end

  // Gain and zero trim with saturation
  logic [32:0] cal_prod;
  logic [16:0] cal_scaled;
  logic signed [18:0] cal_sum;
  logic [15:0] cal_code;
  logic [15:0] target_code;

  always_comb begin
    cal_prod = 33'(data_code_reg) * 33'({1'b0, I_GAIN_TRIM} + GAIN_OFFSET);
    cal_scaled = cal_prod[32:16];
    cal_sum = $signed({2'b00, cal_scaled}) + $signed({{3{I_ZERO_TRIM[15]}}, I_ZERO_TRIM});
    if (cal_sum < 0) begin
      cal_code = 16'h0000;
    end else if (cal_sum > $signed({3'b000, CODE_MAX})) begin
      cal_code = CODE_MAX;
    end else begin
      cal_code = cal_sum[15:0];
    end
    if (clear_hold_reg || clear_lvl) begin
      target_code = CLEAR_CODE;
    end else begin
      target_code = cal_code;
    end
  end

  // Digital slew stepper
  logic slew_en;
  logic [2:0] slew_step_select;
  logic [3:0] slew_rate_select;
  logic [15:0] slew_step;
  logic [SLEW_CNT_W-1:0] slew_cnt_reg;
  logic slew_tick;
  logic [15:0] out_next;
  logic slew_in_progress_reg;

  assign slew_en = I_SLEW_CONTROL[SLEW_EN_BIT];
  assign slew_step_select = I_SLEW_CONTROL[SLEW_STEP_LSB+:3];
  assign slew_rate_select = I_SLEW_CONTROL[SLEW_RATE_LSB+:4];
  assign slew_step = 16'h0001 << slew_step_select;
  assign slew_tick = slew_cnt_reg == (slew_limit(slew_rate_select) - 1'b1);

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || !slew_en || (O_OUTPUT_CODE == target_code) || slew_tick) begin
      slew_cnt_reg <= '0;
    end else begin
      slew_cnt_reg <= slew_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    out_next = O_OUTPUT_CODE;
    if (!slew_en) begin
      out_next = target_code;
    end else if (slew_tick) begin
      if (O_OUTPUT_CODE < target_code) begin
        if (target_code - O_OUTPUT_CODE > slew_step) begin
          out_next = O_OUTPUT_CODE + slew_step;
        end else begin
          out_next = target_code;
        end
      end else if (O_OUTPUT_CODE > target_code) begin
        if (O_OUTPUT_CODE - target_code > slew_step) begin
          out_next = O_OUTPUT_CODE - slew_step;
        end else begin
          out_next = target_code;
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_OUTPUT_CODE <= CODE_RESET;
      slew_in_progress_reg <= 1'b0;
    end else begin
      O_OUTPUT_CODE <= out_next;
      slew_in_progress_reg <= slew_en && (out_next != target_code);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_STATUS <= STATUS_RESET;
    end else begin
      O_STATUS <= STATUS_RESET;
      O_STATUS[STAT_SLEW_BIT] <= slew_in_progress_reg;
      O_STATUS[STAT_CHECK_FAULT_BIT] <= crc_fault_reg;
      O_STATUS[STAT_KEEPALIVE_FAULT_BIT] <= ka_fault_reg;
    end
  end

  // Readback frame, shifted out on falling serial clock edges
  logic [31:0] tx_shift_reg;
  logic [23:0] rb_content;

  assign rb_content = {READBACK_ADDR, O_OUTPUT_CODE};

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      tx_shift_reg <= 32'h00000000;
    end else if (latch_rise) begin
      if (frame_ok && (rx_addr == READBACK_ADDR)) begin
        if (I_FRAME_CHECK_ENABLE) begin
          tx_shift_reg <= {rb_content, crc8({8'h00, rb_content}, PLAIN_FRAME_BITS)};
        end else begin
          tx_shift_reg <= {rb_content, 8'h00};
        end
      end else begin
        tx_shift_reg <= 32'h00000000;
      end
    end else if (sclk_fall) begin
      tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_SDO <= 1'b0;
    end else begin
      O_SDO <= tx_shift_reg[31];
    end
  end

endmodule

// ==== sim/dlgcs_top_assertions.sv ====
// Concurrent checks on the top ports of the guard block.
// Assumes it is bound to dlgcs_top.
`timescale 1ns/10ps
module dlgcs_top_assertions (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_KEEPALIVE_ENABLE,
  input wire logic I_FRAME_CHECK_ENABLE,
  input wire logic [15:0] I_SLEW_CONTROL,
  input wire logic O_ALARM_O,
  input wire logic O_ALARM_OE,
  input wire logic [7:0] O_STATUS,
  input wire logic [15:0] O_OUTPUT_CODE,
  input wire logic O_WRITE_STROBE,
  input wire logic [7:0] O_WRITE_ADDR
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  logic [15:0] prev_reg;
  logic slew_reg;
  logic [15:0] diff;
  always_ff @(posedge I_REF_CLK) begin
    prev_reg <= O_OUTPUT_CODE;
    slew_reg <= I_SLEW_CONTROL[4];
  end
  assign diff = (O_OUTPUT_CODE > prev_reg) ? O_OUTPUT_CODE - prev_reg : prev_reg - O_OUTPUT_CODE;
  sequence ka_off;
    !I_KEEPALIVE_ENABLE [*4];
  endsequence
  sequence chk_off;
    !I_FRAME_CHECK_ENABLE [*4];
  endsequence
  a_alarm_low: assert property (O_ALARM_O == 1'b0) else $error("alarm value high");
  a_oe_keepalive: assert property ($rose(O_STATUS[4]) |-> ##[0:2] O_ALARM_OE)
    else $error("alarm not pulled on keep-alive fault");
  a_oe_check: assert property ($rose(O_STATUS[3]) |-> ##[0:2] O_ALARM_OE)
    else $error("alarm not pulled on check fault");
  a_ka_off: assert property (ka_off |-> !O_STATUS[4]) else $error("keep-alive flag while off");
  a_chk_off: assert property (chk_off |-> !O_STATUS[3]) else $error("check flag while off");
  a_strobe_pulse: assert property (O_WRITE_STROBE |=> !O_WRITE_STROBE)
    else $error("strobe longer than one cycle");
  a_addr_hold: assert property (!O_WRITE_STROBE |-> $stable(O_WRITE_ADDR))
    else $error("address moved without strobe");
  a_step_size: assert property (slew_reg && I_SLEW_CONTROL[4] |->
    diff <= (16'h0001 << I_SLEW_CONTROL[7:5])) else $error("slew step too large");
  a_slew_flag: assert property (slew_reg && I_SLEW_CONTROL[4] && diff != 0 |->
    ##[0:2] O_STATUS[1]) else $error("slew flag low while moving");
endmodule

// ==== sim/dlgcs_host_model.sv ====
// Serial host model: shifts 24- or 32-bit frames, then pulses the latch.
// Assumes the bench calls send; the link clock idles low between frames.
`timescale 1ns/10ps
module dlgcs_host_model (
  output logic o_sclk,
  output logic o_sdi,
  output logic o_latch
);
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_latch = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [23:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] a, input logic [15:0] d, input bit chk, input bit bad);
    logic [31:0] f;
    f = {a, d, crc8({a, d}) ^ {7'h00, bad}};
    #3;
    for (int i = 31; i >= (chk ? 0 : 8); i--) begin
      o_sdi = f[i];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    o_sdi = ~o_sdi;
    #40 o_latch = 1'b1;
    #64 o_latch = 1'b0;
    #64;
  endtask
endmodule

// ==== sim/dlgcs_top_tb.sv ====
// Self-checking bench for the link guard, trim and slew block.
// Assumes the host model drives the link pins and the bench the rest.
`timescale 1ns/10ps
module dlgcs_top_tb;
  import dlgcs_pkg::*;
  localparam int KDIV = 1000;
  logic clk, rst, sclk, sdi, latch, clr, ka_en, chk_en;
  logic [1:0] ka_sel;
  logic [15:0] gain, zero, slew, code, wdata;
  logic al_o, al_oe, stb;
  logic [7:0] stat, waddr;
  int fails, compares, nstb;
  dlgcs_top #(.KA_TIME_DIV(KDIV), .SLEW_TIME_DIV(16)) u_dlgcs_top (
    .I_REF_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_SDI(sdi), .I_LATCH(latch),
    .I_CLEAR_INPUT(clr), .I_KEEPALIVE_ENABLE(ka_en), .I_KEEPALIVE_PERIOD_SELECT(ka_sel),
    .I_FRAME_CHECK_ENABLE(chk_en), .I_SOFT_RESET(1'b0), .I_POWER_DOWN(1'b0),
    .I_GAIN_TRIM(gain), .I_ZERO_TRIM(zero), .I_SLEW_CONTROL(slew), .O_SDO(),
    .O_ALARM_O(al_o), .O_ALARM_OE(al_oe), .O_STATUS(stat), .O_OUTPUT_CODE(code),
    .O_WRITE_STROBE(stb), .O_WRITE_ADDR(waddr), .O_WRITE_DATA(wdata));
  dlgcs_host_model u_dlgcs_host_model (.o_sclk(sclk), .o_sdi(sdi), .o_latch(latch));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (stb === 1'b1) nstb++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] d);
    u_dlgcs_host_model.send(DATA_ADDR, d, chk_en, 1'b0);
    tick(4);
  endtask
  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_cal;
    wr(16'h8000);
    chk(code, 16'h4000);
    gain = 16'h8000;
    zero = 16'h0010;
    wr(16'h1000);
    chk(code, 16'h1010);
    wr(16'hfff8);
    chk(code, 16'hffff);
    zero = 16'hfff0;
    wr(16'h0008);
    chk(code, 16'h0000);
    zero = 16'h0000;
    $display("t_cal done");
  endtask
  task automatic t_crc;
    int n;
    chk_en = 1'b1;
    tick(2);
    wr(16'h1234);
    chk(wdata, 16'h1234);
    chk(16'(waddr), 16'(DATA_ADDR));
    n = nstb;
    u_dlgcs_host_model.send(DATA_ADDR, 16'h5678, 1'b1, 1'b1);
    tick(4);
    chk(16'(nstb - n), 16'h0000);
    chk(wdata, 16'h1234);
    chk(code, 16'h1234);
    chk(16'(stat[3]), 16'h0001);
    chk(16'(al_oe), 16'h0001);
    chk_en = 1'b0;
    tick(4);
    chk(16'(stat[3]), 16'h0000);
    $display("t_crc done");
  endtask
  task automatic t_slew;
    int n;
    slew = 16'h00f0;
    tick(2);
    wr(16'h1534);
    chk(16'(stat[1]), 16'h0001);
    chk(16'(code != 16'h1534), 16'h0001);
    n = 0;
    while (stat[1] !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk(code, 16'h1534);
    chk(16'(n > 110 && n < 200), 16'h0001);
    clr = 1'b1;
    n = 0;
    while (code !== 16'h0000 && n < 2000) begin
      tick(1);
      n++;
    end
    chk(code, 16'h0000);
    chk(16'(n > 1000), 16'h0001);
    clr = 1'b0;
    slew = 16'h0000;
    tick(4);
    $display("t_slew done");
  endtask
  task automatic t_ka;
    int lim, n;
    for (int p = 0; p < 4; p++) begin
      ka_sel = 2'(p);
      ka_en = 1'b1;
      u_dlgcs_host_model.send(KEEPALIVE_ADDR, 16'h0000, 1'b0, 1'b0);
      lim = KA_PERIOD_MS[p] * CLK_PER_MS / KDIV;
      n = 0;
      while (stat[4] !== 1'b1 && n < lim + 50) begin
        tick(1);
        n++;
      end
      chk(16'(n > lim - 40 && n <= lim + 5), 16'h0001);
      tick(2);
      chk(16'(al_oe), 16'h0001);
      ka_en = 1'b0;
      tick(4);
      chk(16'(stat[4]), 16'h0000);
      chk(16'(al_oe), 16'h0000);
    end
    $display("t_ka done");
  endtask
  initial begin
    rst = 1'b1;
    clr = 1'b0;
    ka_en = 1'b0;
    ka_sel = 2'h0;
    chk_en = 1'b0;
    gain = 16'h0000;
    zero = 16'h0000;
    slew = 16'h0000;
    fails = 0;
    compares = 0;
    nstb = 0;
    tick(4);
    rst = 1'b0;
    tick(2);
    chk(16'(stat), 16'h0000);
    t_cal;
    t_crc;
    t_slew;
    t_ka;
    give_verdict;
  end
endmodule
bind dlgcs_top dlgcs_top_assertions u_dlgcs_top_assertions (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_KEEPALIVE_ENABLE(I_KEEPALIVE_ENABLE),
  .I_FRAME_CHECK_ENABLE(I_FRAME_CHECK_ENABLE), .I_SLEW_CONTROL(I_SLEW_CONTROL),
  .O_ALARM_O(O_ALARM_O), .O_ALARM_OE(O_ALARM_OE), .O_STATUS(O_STATUS),
  .O_OUTPUT_CODE(O_OUTPUT_CODE), .O_WRITE_STROBE(O_WRITE_STROBE), .O_WRITE_ADDR(O_WRITE_ADDR));
